// ### design/hpl_latch.sv
/*
 * Output state machine of a zero-cross latching magnetic pole detector.
 * Assumes three comparator levels arriving asynchronously from the analogue front end,
 * a free-running internal clock and a synchronous power-on reset; the pin driver is outside.
 */
`timescale 1ns/1ps
`default_nettype none
`include "hpl_defs.svh"

module hpl_latch
    import hpl_pkg::*;
#(
    parameter logic LOW_AT_SOUTH = `HPL_LOW_AT_SOUTH,
    parameter int OUTPUT_DELAY_CYCLES = `HPL_OUTPUT_DELAY_CYCLES,
    parameter int STARTUP_CYCLES = `HPL_STARTUP_CYCLES,
    parameter int TIMER_WIDTH = `HPL_TIMER_WIDTH
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire hpl_flux_type flux_compare,
    output logic sensor_output,
    output logic hold_active,
    output logic detect_enabled
);

    // Interval loads, cut to the counter width once here.
    localparam logic [TIMER_WIDTH-1:0] OUTPUT_DELAY_LOAD = TIMER_WIDTH'(OUTPUT_DELAY_CYCLES);
    localparam logic [TIMER_WIDTH-1:0] STARTUP_LOAD = TIMER_WIDTH'(STARTUP_CYCLES);

    hpl_latch_state_type cur;
    hpl_latch_state_type next_cur;

    logic timer_start;
    logic [TIMER_WIDTH-1:0] timer_load;
    logic timer_done;

    // Output level for a pole side; the only place where the variant matters.
    function automatic logic pole_level(input logic south);
        pole_level = LOW_AT_SOUTH ? ~south : south;
    endfunction : pole_level

    // True when the synchronised flux lies beyond either release level.
    function automatic logic beyond_release(input hpl_flux_type f);
        beyond_release = f.above_south_release | f.below_north_release;
    endfunction : beyond_release

    // Shared interval counter; only one interval is ever running at a time.
    hpl_delay_timer #(
        .WIDTH(TIMER_WIDTH)
    ) u_timer (
        .clk(clk),
        .rst_b(rst_b),
        .start(timer_start),
        .load_value(timer_load),
        .done(timer_done),
        .busy()
    );

    // Next-state logic. The comparator bits come from the analogue side, so the
    // first sampling stage feeds only the second; all decisions read the second.
    always_comb begin
        next_cur = cur;
        timer_start = 1'b0;
        timer_load = OUTPUT_DELAY_LOAD;

        // Two-stage sampling of the comparator levels on the internal clock.
        next_cur.flux_meta = flux_compare;
        next_cur.flux = cur.flux_meta;

        case (cur.st)
            HPL_ST_STARTUP: begin
                // The output stays at its reset value, high, all through this state.
                next_cur.sensor_output = 1'b1;
                if (!cur.timer_issued) begin
                    timer_start = 1'b1;
                    timer_load = STARTUP_LOAD;
                    next_cur.timer_issued = 1'b1;
                end else if (timer_done) begin
                    next_cur.timer_issued = 1'b0;
                    if (beyond_release(cur.flux)) begin
                        // Flux already past a release level: take the pole level at once.
                        next_cur.side_south = cur.flux.above_south_release;
                        next_cur.sensor_output = pole_level(cur.flux.above_south_release);
                        next_cur.detect_enabled = 1'b1;
                        next_cur.st = HPL_ST_ARMED;
                    end else begin
                        // Flux in the middle band: wait, output still high.
                        next_cur.st = HPL_ST_WAIT_RELEASE;
                    end
                end
            end

            HPL_ST_WAIT_RELEASE: begin
                // Zero crossings mean nothing until a release level has been passed.
                if (beyond_release(cur.flux)) begin
                    next_cur.target_south = cur.flux.above_south_release;
                    timer_start = 1'b1;
                    next_cur.st = HPL_ST_DELAY_RELEASE;
                end
            end

            HPL_ST_DELAY_RELEASE: begin
                // The first pole level appears one output delay after the release level.
                if (timer_done) begin
                    next_cur.side_south = cur.target_south;
                    next_cur.sensor_output = pole_level(cur.target_south);
                    next_cur.detect_enabled = 1'b1;
                    next_cur.st = HPL_ST_ARMED;
                end
            end

            HPL_ST_ARMED: begin
                // Armed from one side, the switch point is the bare zero-cross
                // comparator: no band around it, hold does the debouncing.
                if (cur.side_south && !cur.flux.above_zero_cross) begin
                    next_cur.target_south = 1'b0;
                    timer_start = 1'b1;
                    next_cur.st = HPL_ST_DELAY_CROSS;
                end else if (!cur.side_south && cur.flux.above_zero_cross) begin
                    next_cur.target_south = 1'b1;
                    timer_start = 1'b1;
                    next_cur.st = HPL_ST_DELAY_CROSS;
                end
            end

            HPL_ST_DELAY_CROSS: begin
                // The toggle is committed once the crossing is seen; a quick
                // return inside the delay does not cancel it.
                if (timer_done) begin
                    next_cur.side_south = cur.target_south;
                    next_cur.sensor_output = pole_level(cur.target_south);
                    next_cur.hold_active = 1'b1;
                    next_cur.st = HPL_ST_HOLD;
                end
            end

            HPL_ST_HOLD: begin
                // The zero-cross bit is not looked at here at all.
                if (cur.flux.above_south_release) begin
                    next_cur.target_south = 1'b1;
                    timer_start = 1'b1;
                    next_cur.st = HPL_ST_DELAY_LEAVE;
                end else if (cur.flux.below_north_release) begin
                    next_cur.target_south = 1'b0;
                    timer_start = 1'b1;
                    next_cur.st = HPL_ST_DELAY_LEAVE;
                end
            end

            HPL_ST_DELAY_LEAVE: begin
                // Output is frozen until the delay runs out.
                if (timer_done) begin
                    // Same side as the last toggle keeps the level; the opposite
                    // side gives the other pole level, which is a toggle.
                    next_cur.side_south = cur.target_south;
                    next_cur.sensor_output = pole_level(cur.target_south);
                    next_cur.hold_active = 1'b0;
                    next_cur.st = HPL_ST_ARMED;
                end
            end

            default: begin
                // An illegal code restarts the power-on sequence with the output high.
                next_cur.st = HPL_ST_STARTUP;
                next_cur.timer_issued = 1'b0;
                next_cur.sensor_output = `HPL_OUTPUT_RESET;
                next_cur.hold_active = 1'b0;
                next_cur.detect_enabled = 1'b0;
            end
        endcase
    end

    // State register; reset is the power-on event of the device.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cur <= '0;
            cur.st <= HPL_ST_STARTUP;
            cur.sensor_output <= `HPL_OUTPUT_RESET;
        end else begin
            cur <= next_cur;
        end
    end

    // Outputs straight from the state register. The reader is expected to
    // sample the pin several times where the supply can jump; nothing here
    // filters for that.
    assign sensor_output = cur.sensor_output;
    assign hold_active = cur.hold_active;
    assign detect_enabled = cur.detect_enabled;

endmodule : hpl_latch

`default_nettype wire

// ### design/hpl_defs.svh
/*
 * Constants of the pole hold latch: clock rate, interval lengths and reset values.
 * Assumes it is included by its bare name from the package and the design modules.
 */
`ifndef HPL_DEFS_SVH
`define HPL_DEFS_SVH

// Internal clock period in nanoseconds (25 MHz).
`define HPL_CLK_PERIOD_NS 40

// Output delay interval, typical figure, in microseconds.
`define HPL_OUTPUT_DELAY_US 8

// Start-up interval, typical figure, in microseconds.
`define HPL_STARTUP_INTERVAL_US 25

// Interval lengths as clock cycle counts (both divide exactly at 40 ns).
`define HPL_OUTPUT_DELAY_CYCLES ((`HPL_OUTPUT_DELAY_US * 1000) / `HPL_CLK_PERIOD_NS)
`define HPL_STARTUP_CYCLES ((`HPL_STARTUP_INTERVAL_US * 1000) / `HPL_CLK_PERIOD_NS)

// Width of the shared interval counter.
`define HPL_TIMER_WIDTH 12

// The output pin reads high from power-on through the start-up interval.
`define HPL_OUTPUT_RESET 1'b1

// Variant select: 1 gives a low output at the south pole, 0 a high one.
`define HPL_LOW_AT_SOUTH 1'b1

`endif

// ### design/hpl_pkg.sv
/*
 * Types of the pole hold latch: comparator bundle, control states and the state record.
 * Assumes the constants header is on the include path.
 */
`default_nettype none
`include "hpl_defs.svh"

package hpl_pkg;

    // Level-compare results of the analogue front end, one bit per threshold.
    typedef struct packed {
        logic above_south_release;
        logic below_north_release;
        logic above_zero_cross;
    } hpl_flux_type;

    // Control states, one-hot.
    typedef enum logic [6:0] {
        HPL_ST_STARTUP       = 7'h01,
        HPL_ST_WAIT_RELEASE  = 7'h02,
        HPL_ST_DELAY_RELEASE = 7'h04,
        HPL_ST_ARMED         = 7'h08,
        HPL_ST_DELAY_CROSS   = 7'h10,
        HPL_ST_HOLD          = 7'h20,
        HPL_ST_DELAY_LEAVE   = 7'h40
    } hpl_state_type;

    // Whole register state of the latch.
    typedef struct packed {
        hpl_flux_type  flux_meta;
        hpl_flux_type  flux;
        hpl_state_type st;
        logic          timer_issued;
        logic          side_south;
        logic          target_south;
        logic          sensor_output;
        logic          hold_active;
        logic          detect_enabled;
    } hpl_latch_state_type;

endpackage : hpl_pkg

`default_nettype wire

// ### design/hpl_delay_timer.sv
/*
 * One-shot down counter that times the start-up and output-delay intervals.
 * Assumes a single clock, synchronous active-low reset, and a start pulse from the same domain.
 */
`timescale 1ns/1ps
`default_nettype none
`include "hpl_defs.svh"

module hpl_delay_timer
    import hpl_pkg::*;
#(
    parameter int WIDTH = `HPL_TIMER_WIDTH
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic start,
    input wire logic [WIDTH-1:0] load_value,
    output logic done,
    output logic busy
);

    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic done;
        logic busy;
    } hpl_timer_state_type;

    hpl_timer_state_type cur;
    hpl_timer_state_type next_cur;

    // A start while running restarts the interval; done pulses for one cycle at the end.
    always_comb begin
        next_cur = cur;
        next_cur.done = 1'b0;
        if (start) begin
            // A zero load would wrap to all ones and run the whole counter range, so it is stretched to one cycle.
            next_cur.count = (load_value == '0) ? {{(WIDTH-1){1'b0}}, 1'b1} : load_value;
            next_cur.busy = 1'b1;
        end else if (cur.busy) begin
            next_cur.count = cur.count - {{(WIDTH-1){1'b0}}, 1'b1};
            if (cur.count == {{(WIDTH-1){1'b0}}, 1'b1}) begin
                next_cur.busy = 1'b0;
                next_cur.done = 1'b1;
            end
        end
    end

    // State register.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign done = cur.done;
    assign busy = cur.busy;

endmodule : hpl_delay_timer

`default_nettype wire

// ### bench/hpl_latch_monitor.sv
/* Port checker of the pole hold latch, bound to every latch instance.
   Assumes one clock, synchronous active-low reset and flux levels held steady through each delay. */
`timescale 1ns/1ps
`default_nettype none
module hpl_latch_monitor
    import hpl_pkg::*;
#(
    parameter logic LOW_AT_SOUTH = 1'b1,
    parameter int OUTPUT_DELAY_CYCLES = 200,
    parameter int STARTUP_CYCLES = 625
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire hpl_flux_type flux_compare,
    input wire logic sensor_output,
    input wire logic hold_active,
    input wire logic detect_enabled
);
    // Window for a delayed action: sync, timer start and commit add a few edges to the delay.
    localparam int DLO = OUTPUT_DELAY_CYCLES + 1;
    localparam int DHI = OUTPUT_DELAY_CYCLES + 7;
    logic [15:0] up_cycles;
    logic pole_level;

    // Level the pin must show for the pole now sensed beyond a release level.
    assign pole_level = LOW_AT_SOUTH ^ flux_compare.above_south_release;

    // Edges since reset release; saturates so long runs never wrap.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            up_cycles <= 16'h0000;
        end else if (up_cycles != 16'hffff) begin
            up_cycles <= up_cycles + 16'h0001;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // A zero crossing toward the pole opposite the armed side.
    sequence s_cross_armed;
        detect_enabled && !hold_active && $changed(flux_compare.above_zero_cross)
            && (flux_compare.above_zero_cross == (sensor_output == LOW_AT_SOUTH));
    endsequence
    sequence s_delayed_toggle;
        ##[DLO:DHI] $changed(sensor_output);
    endsequence

    a_reset_values: assert property (disable iff (1'b0) !rst_b |=> sensor_output && !hold_active && !detect_enabled)
        else $error("outputs not at reset values");
    a_startup_quiet: assert property (int'(up_cycles) < STARTUP_CYCLES |-> sensor_output && !detect_enabled)
        else $error("output moved inside start-up");
    a_high_until_detect: assert property (!detect_enabled |-> sensor_output)
        else $error("output low before detection enabled");
    a_cross_toggles: assert property (s_cross_armed |-> s_delayed_toggle)
        else $error("zero crossing did not toggle in time");
    a_hold_entry: assert property ($rose(hold_active) |-> $changed(sensor_output))
        else $error("hold entered without toggle");
    a_hold_freezes: assert property (hold_active && $stable(hold_active) |-> $stable(sensor_output))
        else $error("output moved in hold");
    a_hold_release: assert property (hold_active && ($rose(flux_compare.above_south_release)
        || $rose(flux_compare.below_north_release)) |-> ##[1:DHI] $fell(hold_active))
        else $error("hold not released in time");
    a_leave_level: assert property ($fell(hold_active) |-> sensor_output == pole_level)
        else $error("wrong level on hold release");
    a_init_level: assert property ($rose(detect_enabled) |-> ##[0:DHI] (sensor_output == pole_level))
        else $error("wrong level after start-up");
endmodule : hpl_latch_monitor

bind hpl_latch hpl_latch_monitor #(
    .LOW_AT_SOUTH(LOW_AT_SOUTH),
    .OUTPUT_DELAY_CYCLES(OUTPUT_DELAY_CYCLES),
    .STARTUP_CYCLES(STARTUP_CYCLES)
) i_hpl_latch_monitor (.clk(clk), .rst_b(rst_b), .flux_compare(flux_compare),
    .sensor_output(sensor_output), .hold_active(hold_active), .detect_enabled(detect_enabled));
`default_nettype wire

// ### bench/hpl_reader.sv
/* Model of the controller that reads the sensor pin.
   Assumes the pin is read on the latch clock; a level counts only after repeated equal reads. */
`timescale 1ns/1ps
`default_nettype none
module hpl_reader #(
    parameter int SAMPLES = 3
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic sensor_output,
    output logic accepted
);
    int same_count;
    logic last_read;

    // Repeated reads filter a glitch from a supply step, at the cost of a few cycles of lag.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            same_count <= 0;
            last_read <= 1'b1;
            accepted <= 1'b1;
        end else begin
            last_read <= sensor_output;
            same_count <= (sensor_output == last_read) ? same_count + 1 : 0;
            if (same_count >= SAMPLES - 1) begin
                accepted <= last_read;
            end
        end
    end
endmodule : hpl_reader
`default_nettype wire

// ### bench/hpl_latch_tb_top.sv
/* Self-checking bench of the pole hold latch in both output variants, with a reading controller.
   Assumes the package, checker and reader are compiled first; intervals are shortened by parameters. */
`timescale 1ns/1ps
`default_nettype none
module hpl_latch_tb_top
    import hpl_pkg::*;
;
    localparam int STARTUP = 20;
    localparam int DELAY = 5;
    localparam int SETTLE = DELAY + 15;
    localparam int LIMIT = 2000;
    logic clk;
    logic rst_b;
    hpl_flux_type flux;
    logic out_low, out_high, hold_low, hold_high, det_low, det_high, accepted;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;
    // Rows hold {flux, pin of the low-at-south variant, hold}; they walk the crossing sequence.
    logic [4:0] rows [11] = '{5'h04, 5'h03, 5'h07, 5'h03, 5'h0a, 5'h02, 5'h05, 5'h14, 5'h03, 5'h07, 5'h14};

    hpl_latch #(.LOW_AT_SOUTH(1'b1), .OUTPUT_DELAY_CYCLES(DELAY), .STARTUP_CYCLES(STARTUP)) i_hpl_latch (
        .clk(clk), .rst_b(rst_b), .flux_compare(flux),
        .sensor_output(out_low), .hold_active(hold_low), .detect_enabled(det_low));
    hpl_latch #(.LOW_AT_SOUTH(1'b0), .OUTPUT_DELAY_CYCLES(DELAY), .STARTUP_CYCLES(STARTUP)) i_hpl_latch_high (
        .clk(clk), .rst_b(rst_b), .flux_compare(flux),
        .sensor_output(out_high), .hold_active(hold_high), .detect_enabled(det_high));
    hpl_reader #(.SAMPLES(3)) i_hpl_reader (.clk(clk), .rst_b(rst_b), .sensor_output(out_low), .accepted(accepted));

    task automatic check(input string name, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %b seen %b", name, exp, got);
        end
    endtask : check

    // Inputs move on the falling edge so the latch samples settled levels.
    task automatic step(input logic [2:0] f, input int n);
        @(negedge clk);
        flux = f;
        repeat (n) @(negedge clk);
    endtask : step

    task automatic summarize();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // A hang is cut short well past the few hundred cycles the tests need.
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            failures++;
            summarize();
        end
    end

    initial begin
        rst_b = 1'b0;
        flux = 3'h5;
        repeat (16) @(negedge clk);
        check("out_in_reset", 1'b1, out_low);
        rst_b = 1'b1;
        repeat (STARTUP - 4) @(negedge clk);
        check("out_startup", 1'b1, out_low);
        check("detect_startup", 1'b0, det_low);
        repeat (SETTLE) @(negedge clk);
        check("out_after_startup", 1'b0, out_low);
        check("out_high_variant", 1'b1, out_high);
        check("detect_after_startup", 1'b1, det_low);
        check("detect_high_variant", 1'b1, det_high);
        $display("test startup done");
        for (int i = 0; i < 11; i++) begin
            step(rows[i][4:2], SETTLE);
            check("out", rows[i][1], out_low);
            check("hold", rows[i][0], hold_low);
            check("out_high_variant", ~rows[i][1], out_high);
            check("hold_high_variant", rows[i][0], hold_high);
            check("reader", rows[i][1], accepted);
        end
        $display("test crossings done");
        // Second reset with the flux between the release levels, so no pole is known yet.
        step(3'h1, 0);
        rst_b = 1'b0;
        repeat (16) @(negedge clk);
        rst_b = 1'b1;
        repeat (STARTUP + SETTLE) @(negedge clk);
        check("out_band", 1'b1, out_low);
        check("detect_band", 1'b0, det_low);
        check("detect_high_band", 1'b0, det_high);
        step(3'h5, DELAY - 2);
        check("out_in_delay", 1'b1, out_low);
        repeat (SETTLE) @(negedge clk);
        check("out_band_south", 1'b0, out_low);
        check("detect_band_south", 1'b1, det_low);
        check("out_high_band_south", 1'b1, out_high);
        $display("test band start done");
        summarize();
    end
endmodule : hpl_latch_tb_top
`default_nettype wire
